// File: scp_prescaler.sv
// system clock prescaler and oscillator trim, ahb-lite register slave
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.

// Overview of operation
// R1 - divided rate drives core, memory, io, converter
// R2 - division change switches without glitches
// R3 - no intermediate rate faster than old/new
// R4 - ripple divider count hidden from software
// R5 - new rate active after old plus new periods
// R6 - exactly two active edges during transition
// R7 - software opens change with enable-only write
// R8 - software writes select within four cycles
// R9 - software masks interrupts during the procedure
// R10 - enable updates only when other bits zero
// R11 - enable clears after four cycles or select write
// R12 - rewriting enable neither restarts nor clears it
// R13 - select codes 0..8 give divide 1..256
// R14 - reset select from divide-by-eight fuse
// R15 - any select value accepted regardless of fuse
// R16 - factory trim loaded into trim at reset
// R17 - trim writable, drives oscillator directly
// R18 - trim top bit selects overlapping range
// R19 - lower trim bits tune monotonically
// R20 - software keeps trim low during memory writes
// R21 - select writes outside window are ignored
// R22 - prescale bits six to four read zero
module scp_prescaler #(
    parameter int PRESCALE_W = scp_pkg::PRESCALE_W
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // straps sampled after reset
    input wire logic boot_divide_by_eight_fuse,
    input wire logic [7:0] factory_trim,
    // divided domain clock enables
    output logic core_domain_clock,
    output logic program_memory_domain_clock,
    output logic io_domain_clock,
    output logic converter_domain_clock,
    // oscillator trim
    output logic [7:0] osc_trim,
    output logic trim_range_bit
);
    scp_pkg::scp_ahb_req_s req;
    scp_pkg::scp_ahb_req_s next_req;
    scp_pkg::scp_chg_e chg_state;
    logic [2:0] window_count;
    logic [3:0] divide_select;
    logic [3:0] active_select;
    logic switch_pending;
    logic straps_loaded;
    logic tick;
    logic restart;
    logic wr_ctrl;
    logic wr_trim;
    logic [7:0] wbyte;
    logic enable_only;
    logic select_write;

    // decode of a readable word
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input logic [7:0] trim,
                                              input logic chg_open,
                                              input logic [3:0] sel,
                                              input logic [3:0] act,
                                              input logic pend);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            scp_pkg::OFS_OSC_TRIM: begin
                d[7:0] = trim;
            end
            scp_pkg::OFS_CLOCK_DIVIDE_CONTROL: begin
                // R22 unused bits read zero
                d[scp_pkg::DIVIDE_CHANGE_ENABLE_BIT] = chg_open;
                d[scp_pkg::DIVIDE_SELECT_LSB +: scp_pkg::DIVIDE_SELECT_W] = sel;
            end
            scp_pkg::OFS_DIVIDE_STATUS: begin
                d[3:0] = act;
                d[4] = pend;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction : read_word

    // reset-time divide select chosen by the fuse
    function automatic logic [3:0] boot_select(input logic fuse);
        logic [3:0] s;
        if (fuse) begin
            s = scp_pkg::DIVIDE_SELECT_FUSE;
        end else begin
            s = scp_pkg::DIVIDE_SELECT_RESET;
        end
        return s;
    endfunction : boot_select

    // data phase write hit on one register
    function automatic logic write_hit(input scp_pkg::scp_ahb_req_s r,
                                       input logic [11:0] ofs);
        return r.valid && r.write && (r.addr == ofs);
    endfunction : write_hit

    // address phase capture
    always_comb begin
        next_req.valid = hsel & hready & htrans[scp_pkg::HTRANS_ACTIVE_BIT];
        next_req.write = hwrite;
        next_req.addr = {haddr[11:2], 2'b00};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (clk_en) begin
            if (hready) begin
                req <= next_req;
            end
        end
    end

    // zero wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // every response is okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (next_req.valid && !next_req.write) begin
                hrdata <= read_word(next_req.addr, osc_trim,
                                    chg_state == scp_pkg::CHG_OPEN,
                                    divide_select, active_select,
                                    switch_pending);
            end
        end
    end

    // data phase write decode
    assign wbyte = hwdata[7:0];
    assign wr_ctrl = write_hit(req, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL);
    assign wr_trim = write_hit(req, scp_pkg::OFS_OSC_TRIM);
    // R10 enable counts only with all other bits zero
    assign enable_only = wr_ctrl && (wbyte == 8'h80);
    // R21 select write needs open window and enable written zero
    assign select_write = wr_ctrl && !wbyte[scp_pkg::DIVIDE_CHANGE_ENABLE_BIT]
                          && (chg_state == scp_pkg::CHG_OPEN);

    // straps are caught on the first enabled edge after release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            straps_loaded <= 1'b0;
        end else if (clk_en) begin
            straps_loaded <= 1'b1;
        end
    end

    // change window state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chg_state <= scp_pkg::CHG_IDLE;
        end else if (clk_en) begin
            case (chg_state)
                scp_pkg::CHG_IDLE: begin
                    // R7 enable-only write opens the window
                    if (enable_only) begin
                        chg_state <= scp_pkg::CHG_OPEN;
                    end
                end
                scp_pkg::CHG_OPEN: begin
                    // R11 closes on select write or after four cycles
                    // R12 a repeat enable write changes nothing
                    if (select_write || window_count == 3'h0) begin
                        chg_state <= scp_pkg::CHG_IDLE;
                    end
                end
                default: begin
                    chg_state <= scp_pkg::CHG_IDLE;
                end
            endcase
        end
    end

    // R11 four-cycle window countdown
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            window_count <= 3'h0;
        end else if (clk_en) begin
            if (chg_state == scp_pkg::CHG_IDLE && enable_only) begin
                window_count <= scp_pkg::CHANGE_WINDOW_CYCLES - 3'h1;
            end else if (chg_state == scp_pkg::CHG_OPEN && !select_write &&
                         window_count != 3'h0) begin
                window_count <= window_count - 3'h1;
            end else begin
                window_count <= 3'h0;
            end
        end
    end

    // programmed divide select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divide_select <= scp_pkg::DIVIDE_SELECT_RESET;
        end else if (clk_en) begin
            if (!straps_loaded) begin
                // R14 fuse chooses divide by eight at start
                divide_select <= boot_select(boot_divide_by_eight_fuse);
            end else if (select_write) begin
                // R15 any value taken whatever the fuse
                divide_select <= wbyte[scp_pkg::DIVIDE_SELECT_LSB +:
                                       scp_pkg::DIVIDE_SELECT_W];
            end
        end
    end

    // active setting follows at the end of the old period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_select <= scp_pkg::DIVIDE_SELECT_RESET;
            switch_pending <= 1'b0;
        end else if (clk_en) begin
            if (!straps_loaded) begin
                active_select <= boot_select(boot_divide_by_eight_fuse);
            end else if (select_write) begin
                switch_pending <= 1'b1;
            end else if (switch_pending && tick) begin
                // R3 old period completes before the new one starts
                // R13 reserved codes run as divide by 256
                active_select <= (divide_select > scp_pkg::DIVIDE_SELECT_MAX) ?
                                 scp_pkg::DIVIDE_SELECT_MAX : divide_select;
                switch_pending <= 1'b0;
            end
        end
    end

    // R5 counter restarts when the new setting takes over
    assign restart = !straps_loaded || (switch_pending && tick && !select_write);

    // R4 divider count stays internal
    scp_div_cell #(
        .W(PRESCALE_W)
    ) u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .restart(restart),
        .code(active_select),
        .tick(tick)
    );

    // R1 core domain enable from the shared tick
    // R2 R6 single-cycle enables give glitch-free switching
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_domain_clock <= 1'b0;
        end else if (clk_en) begin
            core_domain_clock <= tick & straps_loaded;
        end
    end

    // R1 program memory domain enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_memory_domain_clock <= 1'b0;
        end else if (clk_en) begin
            program_memory_domain_clock <= tick & straps_loaded;
        end
    end

    // R1 io domain enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_domain_clock <= 1'b0;
        end else if (clk_en) begin
            io_domain_clock <= tick & straps_loaded;
        end
    end

    // R1 converter domain enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            converter_domain_clock <= 1'b0;
        end else if (clk_en) begin
            converter_domain_clock <= tick & straps_loaded;
        end
    end

    // oscillator trim register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_trim <= scp_pkg::OSC_TRIM_RESET;
        end else if (clk_en) begin
            if (!straps_loaded) begin
                // R16 factory value loaded after reset
                osc_trim <= factory_trim;
            end else if (wr_trim) begin
                // R17 R19 written code drives oscillator tuning
                osc_trim <= wbyte;
            end
        end
    end

    // R18 range select mirrors trim top bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_range_bit <= scp_pkg::OSC_TRIM_RESET[scp_pkg::TRIM_RANGE_BIT];
        end else if (clk_en) begin
            if (!straps_loaded) begin
                trim_range_bit <= factory_trim[scp_pkg::TRIM_RANGE_BIT];
            end else if (wr_trim) begin
                trim_range_bit <= wbyte[scp_pkg::TRIM_RANGE_BIT];
            end
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:8]};
endmodule : scp_prescaler

// File: scp_div_cell.sv
// shared constants and the prescale ripple counter cell
package scp_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_OSC_TRIM = 12'h000;
    localparam logic [11:0] OFS_CLOCK_DIVIDE_CONTROL = 12'h004;
    localparam logic [11:0] OFS_DIVIDE_STATUS = 12'h008;
    // clock_divide_control field positions
    localparam int DIVIDE_CHANGE_ENABLE_BIT = 7;
    localparam int DIVIDE_SELECT_LSB = 0;
    localparam int DIVIDE_SELECT_W = 4;
    // osc_trim field positions
    localparam int TRIM_RANGE_BIT = 7;
    localparam int TRIM_TUNE_W = 7;
    // reset values and the largest select code
    localparam logic [3:0] DIVIDE_SELECT_RESET = 4'h0;
    localparam logic [3:0] DIVIDE_SELECT_FUSE = 4'h3;
    localparam logic [7:0] OSC_TRIM_RESET = 8'h00;
    localparam logic [3:0] DIVIDE_SELECT_MAX = 4'h8;
    // change window length in cycles
    localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
    // prescale counter width
    localparam int PRESCALE_W = 8;
    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    // captured address phase of an ahb transfer
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } scp_ahb_req_s;

    // state of the protected change procedure
    typedef enum logic [1:0] {
        CHG_IDLE,
        CHG_OPEN
    } scp_chg_e;
endpackage : scp_pkg

// ripple-carry prescale counter; its count is never exposed to software
module scp_div_cell #(
    parameter int W = scp_pkg::PRESCALE_W
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // control
    input wire logic restart,
    input wire logic [3:0] code,
    // result
    output logic tick
);
    logic [W-1:0] count;
    logic [W-1:0] mask;
    logic [W:0] carry;

    // mask of low bits that must all be one for a period end
    function automatic logic [W-1:0] period_mask(input logic [3:0] c);
        logic [W-1:0] m;
        m = '0;
        for (int i = 0; i < W; i++) begin
            if (i < int'(c)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : period_mask

    assign mask = period_mask(code);

    // R4 ripple carry chain
    always_comb begin
        carry[0] = 1'b1;
        for (int i = 0; i < W; i++) begin
            carry[i+1] = carry[i] & count[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (clk_en) begin
            if (restart) begin
                count <= '0;
            end else begin
                count <= count ^ carry[W-1:0];
            end
        end
    end

    // R13 period end at two to the code
    assign tick = ((count & mask) == mask);
endmodule : scp_div_cell

// File: scp_prescaler_assertions.sv
// port assertions for the clock prescaler and trim register
module scp_prescaler_chk #(
    parameter int PRESCALE_W = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // divided enables and trim
    input wire logic core_domain_clock,
    input wire logic program_memory_domain_clock,
    input wire logic io_domain_clock,
    input wire logic converter_domain_clock,
    input wire logic [7:0] osc_trim,
    input wire logic trim_range_bit
);
    logic taken;
    logic rd_trim;
    logic rd_ctl;
    logic wr_trim;
    logic started;
    assign taken = hsel && hready && htrans[1] && clk_en;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_trim <= 1'b0;
            rd_ctl <= 1'b0;
            wr_trim <= 1'b0;
            started <= 1'b0;
        end else begin
            rd_trim <= taken && !hwrite && haddr[11:2] == 10'h000;
            rd_ctl <= taken && !hwrite && haddr[11:2] == 10'h001;
            wr_trim <= taken && hwrite && haddr[11:2] == 10'h000;
            started <= started || clk_en;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");
    a_domains_equal: assert property (core_domain_clock == io_domain_clock
        && core_domain_clock == program_memory_domain_clock
        && core_domain_clock == converter_domain_clock)
        else $error("domain enables differ");
    a_range_bit: assert property (trim_range_bit == osc_trim[7])
        else $error("range bit differs from trim top bit");
    a_trim_update: assert property ($changed(osc_trim) |->
        $past(wr_trim) || !$past(started))
        else $error("trim changed without a write");
    a_trim_read: assert property (rd_trim |->
        hrdata == {24'h0, $past(osc_trim)})
        else $error("trim read data wrong");
    a_ctl_zero_bits: assert property (rd_ctl |->
        hrdata[6:4] == 3'h0 && hrdata[31:8] == 24'h0)
        else $error("control unused bits not zero");
    a_freeze_hold: assert property (!clk_en |=>
        $stable(osc_trim) && $stable(core_domain_clock))
        else $error("state moved while disabled");
    a_pulse_alive: assert property (!core_domain_clock |->
        ##[1:800] core_domain_clock)
        else $error("divided enable stalled");
endmodule : scp_prescaler_chk

bind scp_prescaler scp_prescaler_chk #(.PRESCALE_W(PRESCALE_W)) chk_u (
    .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .core_domain_clock,
    .program_memory_domain_clock, .io_domain_clock,
    .converter_domain_clock, .osc_trim, .trim_range_bit
);

// File: scp_prescaler_test.sv
// self-checking bench for the clock prescaler and trim register
module scp_prescaler_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic fuse = 1'b0;
    logic [7:0] ftrim = 8'h00;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic core;
    logic [7:0] trim;
    logic rbit;
    logic [31:0] rd;
    int error_cnt = 0;
    int comparisons = 0;
    always #25 hclk = ~hclk;
    scp_prescaler dut_u (
        .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .boot_divide_by_eight_fuse(fuse), .factory_trim(ftrim),
        .core_domain_clock(core), .program_memory_domain_clock(),
        .io_domain_clock(), .converter_domain_clock(),
        .osc_trim(trim), .trim_range_bit(rbit)
    );
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                error_cnt++;
                $display("[FAIL] %0t bus wait ran out", $time);
                close_out();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic next_pulse(output int n);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (core !== 1'b1 && n < 2000);
        if (core !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t pulse wait ran out", $time);
            close_out();
        end
    endtask : next_pulse
    task automatic gap(input int exp, input int lo);
        int n;
        next_pulse(n);
        next_pulse(n);
        chk(32'(n >= lo), 32'h1);
        next_pulse(n);
        chk(32'(n), 32'(exp));
    endtask : gap
    task automatic t_reset;
        for (int f = 0; f < 2; f++) begin
            @(posedge hclk);
            hresetn <= 1'b0;
            fuse <= f[0];
            ftrim <= 8'h5a + 8'(f);
            repeat (8) @(posedge hclk);
            hresetn <= 1'b1;
            xfer(1'b0, scp_pkg::OFS_OSC_TRIM, 32'h0);
            chk(rd, 32'h5a + 32'(f));
            xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
            chk(rd, f ? 32'h3 : 32'h0);
            gap(f ? 8 : 1, f ? 8 : 1);
        end
        $display("reset test done");
    endtask : t_reset
    task automatic t_codes;
        int prev;
        int e;
        prev = 1 << scp_pkg::DIVIDE_SELECT_FUSE;
        for (int c = 0; c < 10; c++) begin
            e = c > 8 ? 256 : 1 << c;
            xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h80);
            xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'(c));
            xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
            chk(rd, 32'(c));
            gap(e, e < prev ? e : prev);
            prev = e;
        end
        $display("code test done");
    endtask : t_codes
    task automatic t_window;
        int n;
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h80);
        xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
        chk(rd, 32'h89);
        xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
        chk(rd, 32'h09);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h2);
        xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
        chk(rd, 32'h09);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h80);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h80);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h2);
        xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
        chk(rd, 32'h09);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h81);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h2);
        xfer(1'b0, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h0);
        chk(rd, 32'h09);
        xfer(1'b1, scp_pkg::OFS_DIVIDE_STATUS, 32'hff);
        xfer(1'b0, scp_pkg::OFS_DIVIDE_STATUS, 32'h0);
        chk(rd, 32'h08);
        next_pulse(n);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h80);
        xfer(1'b1, scp_pkg::OFS_CLOCK_DIVIDE_CONTROL, 32'h08);
        xfer(1'b0, scp_pkg::OFS_DIVIDE_STATUS, 32'h0);
        chk(rd, 32'h18);
        xfer(1'b1, 12'h00c, 32'hff);
        xfer(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        $display("window test done");
    endtask : t_window
    task automatic t_trim;
        logic [7:0] v[4] = '{8'h00, 8'h7f, 8'h80, 8'ha5};
        int n;
        foreach (v[i]) begin
            xfer(1'b1, scp_pkg::OFS_OSC_TRIM, {24'h0, v[i]});
            xfer(1'b0, scp_pkg::OFS_OSC_TRIM, 32'h0);
            chk(rd, {24'h0, v[i]});
            chk({24'h0, trim}, {24'h0, v[i]});
            chk({31'h0, rbit}, {31'h0, v[i][7]});
        end
        next_pulse(n);
        @(posedge hclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge hclk);
        clk_en <= 1'b1;
        next_pulse(n);
        chk(32'(n), 32'h100);
        chk({24'h0, trim}, 32'ha5);
        $display("trim test done");
    endtask : t_trim
    initial begin
        t_reset();
        t_codes();
        t_window();
        t_trim();
        close_out();
    end
    initial begin
        #4000000;
        error_cnt++;
        $display("[FAIL] %0t run limit reached", $time);
        close_out();
    end
endmodule : scp_prescaler_test
